// ===== hdl/cal_ctrl_pkg.sv
/*
  Constants, types and register map of the converter calibration control bank.
  Assumes one synchronous clock domain and a plain address/strobe register port.
*/
`default_nettype none
package cal_ctrl_pkg;

  // register byte addresses
  localparam logic [7:0] ADDR_TRIG_CTRL = 8'h6B;
  localparam logic [7:0] ADDR_SOFT_TRIG = 8'h6C;
  localparam logic [7:0] ADDR_LP_CTRL = 8'h6E;
  localparam logic [7:0] ADDR_STATUS = 8'h6F;
  localparam logic [7:0] ADDR_DATA_EN = 8'h70;
  localparam logic [7:0] ADDR_DATA_PORT = 8'h71;
  localparam logic [7:0] ADDR_GAIN_A = 8'h7A;

  // reset values
  localparam logic [7:0] RST_TRIG_CTRL = 8'h00;
  localparam logic [7:0] RST_SOFT_TRIG = 8'h01;
  localparam logic [7:0] RST_LP_CTRL = 8'h48;
  localparam logic [7:0] RST_DATA_EN = 8'h00;

  // field positions
  localparam int LOW_POWER_CAL_ENABLE_BIT = 0;
  localparam int LP_MODE_BIT = 1;
  localparam int WAKE_LSB = 3;
  localparam int WAKE_MSB = 4;
  localparam int SLEEP_LSB = 5;
  localparam int SLEEP_MSB = 7;
  localparam int SRC_SEL_BIT = 0;
  localparam int BG_EN_BIT = 1;
  localparam int SOFT_TRIG_BIT = 0;
  localparam int DATA_EN_BIT = 0;

  // calibration vector
  localparam int CAL_LEN = 673;
  localparam int IDX_W = 10;
  localparam logic [IDX_W-1:0] IDX_LAST = 10'h2A0;
  localparam logic [IDX_W-1:0] IDX_ZERO = 10'h000;

  // delay exponents per code, code 0 in the low slot
  localparam logic [7:0][5:0] SLEEP_EXP = {
    6'h21, 6'h1E, 6'h1B, 6'h18, 6'h15, 6'h10, 6'h0F, 6'h03};
  localparam logic [3:0][5:0] WAKE_EXP = {6'h18, 6'h15, 6'h12, 6'h03};
  localparam int CNT_W = 42;
  localparam int DLY_UNIT_CLKS = 256;
  localparam logic [CNT_W-1:0] CAL_RUN_CLKS = 42'h000_0000_0010;
  localparam logic [CNT_W-1:0] CNT_ONE = 42'h000_0000_0001;
  localparam logic [CNT_W-1:0] CNT_ZERO = 42'h000_0000_0000;

  typedef enum logic [3:0] {
    ST_HALT = 4'b0001,
    ST_CAL = 4'b0010,
    ST_SLEEP = 4'b0100,
    ST_WAKE = 4'b1000
  } eng_state_e;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic we;
    logic re;
  } reg_req_s;

endpackage
`default_nettype wire

// ===== hdl/cal_ctrl_regs.sv
/*
  Calibration control register bank with low-power sleep/wake scheduler
  and the byte-serial calibration vector port.
  Assumes a register master with one-cycle strobes and synchronous inputs.
*/
`timescale 1ns/1ps
`default_nettype none
module cal_ctrl_regs
  import cal_ctrl_pkg::*;
#(
  parameter int unsigned DLY_UNIT = DLY_UNIT_CLKS,
  parameter logic [7:0] GAIN_TRIM_A_FACTORY = 8'h80
) (
  // clock and reset
  input wire logic mclk_i,
  input wire logic rst_i,
  // register port
  input wire reg_req_s reg_req_i,
  output logic [7:0] rd_data_o,
  // calibration trigger
  input wire logic hardware_cal_trigger_i,
  // engine state and trims
  output logic core_sleep_o,
  output logic cal_running_o,
  output logic [7:0] gain_trim_a_o
);

  function automatic logic hit(input reg_req_s r, input logic [7:0] a);
    return r.addr == a;
  endfunction

  function automatic logic [CNT_W-1:0] lp_delay(input logic [5:0] k,
                                               input logic [CNT_W-1:0] unit);
    return ((CNT_ONE << k) + CNT_ONE) * unit;
  endfunction

  function automatic logic [IDX_W-1:0] idx_next(input logic [IDX_W-1:0] i);
    return (i == IDX_LAST) ? IDX_ZERO : i + IDX_W'(1);
  endfunction

  logic [7:0] trig_ctrl_q;
  logic [7:0] soft_trig_q;
  logic [7:0] lp_ctrl_q;
  logic [7:0] data_en_q;
  logic [7:0] gain_a_q;
  logic [7:0] rd_data_q;
  logic [IDX_W-1:0] idx_q;
  logic [7:0] cal_mem_q [CAL_LEN];
  logic [CNT_W-1:0] cnt_q;
  eng_state_e state_q;

  logic [CNT_W-1:0] unit;
  logic [CNT_W-1:0] sleep_dly;
  logic [CNT_W-1:0] wake_dly;
  logic port_en;
  logic port_wr;
  logic port_rd;
  logic trig;
  logic bg_en;
  logic low_power_cal_enable;
  logic lp_mode;
  logic [7:0] cur_byte;
  logic [7:0] status;

  assign unit = CNT_W'(DLY_UNIT);
  assign sleep_dly = lp_delay(SLEEP_EXP[lp_ctrl_q[SLEEP_MSB:SLEEP_LSB]], unit);
  assign wake_dly = lp_delay(WAKE_EXP[lp_ctrl_q[WAKE_MSB:WAKE_LSB]], unit);
  assign port_en = data_en_q[DATA_EN_BIT];
  assign port_wr = reg_req_i.we && hit(reg_req_i, ADDR_DATA_PORT) && port_en;
  assign port_rd = reg_req_i.re && hit(reg_req_i, ADDR_DATA_PORT) && port_en;
  assign bg_en = trig_ctrl_q[BG_EN_BIT];
  assign low_power_cal_enable = lp_ctrl_q[LOW_POWER_CAL_ENABLE_BIT];
  assign lp_mode = lp_ctrl_q[LP_MODE_BIT];
  assign cur_byte = cal_mem_q[idx_q];
  assign status = {4'h0, state_q == ST_CAL, state_q == ST_WAKE,
                   state_q == ST_SLEEP, state_q == ST_HALT};

  // trigger source mux
  assign trig = trig_ctrl_q[SRC_SEL_BIT] ? hardware_cal_trigger_i
                                         : soft_trig_q[SOFT_TRIG_BIT];

  // control registers
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      trig_ctrl_q <= RST_TRIG_CTRL;
      soft_trig_q <= RST_SOFT_TRIG;
      lp_ctrl_q <= RST_LP_CTRL;
      data_en_q <= RST_DATA_EN;
    end else if (reg_req_i.we) begin
      if (hit(reg_req_i, ADDR_TRIG_CTRL)) begin
        trig_ctrl_q <= reg_req_i.wdata;
      end
      if (hit(reg_req_i, ADDR_SOFT_TRIG)) begin
        soft_trig_q <= reg_req_i.wdata;
      end
      if (hit(reg_req_i, ADDR_LP_CTRL)) begin
        lp_ctrl_q <= reg_req_i.wdata;
      end
      if (hit(reg_req_i, ADDR_DATA_EN)) begin
        data_en_q <= reg_req_i.wdata;
      end
    end
  end

  // gain trim, factory value at reset
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      gain_a_q <= GAIN_TRIM_A_FACTORY;
    end else if (reg_req_i.we && hit(reg_req_i, ADDR_GAIN_A)) begin
      gain_a_q <= reg_req_i.wdata;
    end
  end

  // vector index
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      idx_q <= IDX_ZERO;
    end else if (!port_en) begin
      idx_q <= IDX_ZERO;
    end else if (port_wr || port_rd) begin
      idx_q <= idx_next(idx_q);
    end
  end

  // vector storage
  always_ff @(posedge mclk_i) begin
    if (port_wr) begin
      cal_mem_q[idx_q] <= reg_req_i.wdata;
    end
  end

  // read data, one cycle after the strobe
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      rd_data_q <= 8'h00;
    end else if (!reg_req_i.re) begin
      rd_data_q <= 8'h00;
    end else begin
      unique case (reg_req_i.addr)
        ADDR_TRIG_CTRL: rd_data_q <= trig_ctrl_q;
        ADDR_SOFT_TRIG: rd_data_q <= soft_trig_q;
        ADDR_LP_CTRL: rd_data_q <= lp_ctrl_q;
        ADDR_STATUS: rd_data_q <= status;
        ADDR_DATA_EN: rd_data_q <= data_en_q;
        ADDR_DATA_PORT: rd_data_q <= port_en ? cur_byte : 8'h00;
        ADDR_GAIN_A: rd_data_q <= gain_a_q;
        default: rd_data_q <= 8'h00;
      endcase
    end
  end

  // sleep/wake scheduler
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      state_q <= ST_HALT;
      cnt_q <= CNT_ZERO;
    end else if (!bg_en) begin
      state_q <= ST_HALT;
      cnt_q <= CNT_ZERO;
    end else begin
      unique case (state_q)
        ST_HALT: begin
          state_q <= ST_CAL;
          cnt_q <= CAL_RUN_CLKS - CNT_ONE;
        end
        ST_CAL: begin
          if (cnt_q != CNT_ZERO) begin
            cnt_q <= cnt_q - CNT_ONE;
          end else if (low_power_cal_enable) begin
            state_q <= ST_SLEEP;
            cnt_q <= lp_mode ? CNT_ZERO : sleep_dly - CNT_ONE;
          end else begin
            cnt_q <= CAL_RUN_CLKS - CNT_ONE;
          end
        end
        ST_SLEEP: begin
          if (!low_power_cal_enable || (lp_mode ? trig : cnt_q == CNT_ZERO)) begin
            state_q <= ST_WAKE;
            cnt_q <= wake_dly - CNT_ONE;
          end else if (!lp_mode) begin
            cnt_q <= cnt_q - CNT_ONE;
          end
        end
        ST_WAKE: begin
          if (cnt_q == CNT_ZERO) begin
            state_q <= ST_CAL;
            cnt_q <= CAL_RUN_CLKS - CNT_ONE;
          end else begin
            cnt_q <= cnt_q - CNT_ONE;
          end
        end
        default: begin
          state_q <= ST_HALT;
          cnt_q <= CNT_ZERO;
        end
      endcase
    end
  end

  assign rd_data_o = rd_data_q;
  assign gain_trim_a_o = gain_a_q;
  assign core_sleep_o = state_q[2];
  assign cal_running_o = state_q[1];

  // checks
  sequence s_port_access;
    port_en && hit(reg_req_i, ADDR_DATA_PORT) && (reg_req_i.we || reg_req_i.re);
  endsequence

  sequence s_enter_sleep;
    state_q == ST_CAL && cnt_q == CNT_ZERO && low_power_cal_enable && bg_en;
  endsequence

  property p_sleep_timed;
    @(posedge mclk_i) disable iff (rst_i)
    s_enter_sleep and !lp_mode |=> state_q == ST_SLEEP && cnt_q == $past(sleep_dly) - CNT_ONE;
  endproperty
  a_sleep_timed: assert property (p_sleep_timed) else $error("sleep count wrong");

  property p_wake_load;
    @(posedge mclk_i) disable iff (rst_i)
    state_q == ST_SLEEP && bg_en && !lp_mode && low_power_cal_enable && cnt_q == CNT_ZERO
      |=> state_q == ST_WAKE && cnt_q == $past(wake_dly) - CNT_ONE;
  endproperty
  a_wake_load: assert property (p_wake_load) else $error("wake count wrong");

  property p_timed_hold;
    @(posedge mclk_i) disable iff (rst_i)
    state_q == ST_SLEEP && bg_en && low_power_cal_enable && !lp_mode && cnt_q != CNT_ZERO
      |=> state_q == ST_SLEEP && cnt_q == $past(cnt_q) - CNT_ONE;
  endproperty
  a_timed_hold: assert property (p_timed_hold) else $error("timed sleep ended early");

  property p_trig_hold;
    @(posedge mclk_i) disable iff (rst_i)
    state_q == ST_SLEEP && bg_en && low_power_cal_enable && lp_mode && !trig |=> state_q == ST_SLEEP;
  endproperty
  a_trig_hold: assert property (p_trig_hold) else $error("woke without trigger");

  property p_lp_off;
    @(posedge mclk_i) disable iff (rst_i)
    !low_power_cal_enable ##1 !low_power_cal_enable |-> state_q != ST_SLEEP;
  endproperty
  a_lp_off: assert property (p_lp_off) else $error("sleeping with low power off");

  property p_gate;
    @(posedge mclk_i) disable iff (rst_i)
    !port_en && reg_req_i.re && hit(reg_req_i, ADDR_DATA_PORT)
      |=> rd_data_o == 8'h00 && idx_q == IDX_ZERO;
  endproperty
  a_gate: assert property (p_gate) else $error("port open while disabled");

  property p_read_next;
    @(posedge mclk_i) disable iff (rst_i)
    s_port_access and reg_req_i.re |=> rd_data_o == $past(cur_byte);
  endproperty
  a_read_next: assert property (p_read_next) else $error("port read wrong byte");

  property p_write_load;
    @(posedge mclk_i) disable iff (rst_i)
    s_port_access and reg_req_i.we |=> cal_mem_q[$past(idx_q)] == $past(reg_req_i.wdata);
  endproperty
  a_write_load: assert property (p_write_load) else $error("port write lost");

  property p_gain;
    @(posedge mclk_i) disable iff (rst_i)
    reg_req_i.we && hit(reg_req_i, ADDR_GAIN_A) |=> gain_trim_a_o == $past(reg_req_i.wdata);
  endproperty
  a_gain: assert property (p_gain) else $error("gain trim not written");

  property p_src_sw;
    @(posedge mclk_i) disable iff (rst_i)
    state_q == ST_SLEEP && bg_en && low_power_cal_enable && lp_mode && !trig_ctrl_q[SRC_SEL_BIT]
      && !soft_trig_q[SOFT_TRIG_BIT] |=> state_q == ST_SLEEP;
  endproperty
  a_src_sw: assert property (p_src_sw) else $error("hardware trigger not ignored");

  property p_idx_step;
    @(posedge mclk_i) disable iff (rst_i)
    s_port_access ##1 port_en |-> idx_q == idx_next($past(idx_q));
  endproperty
  a_idx_step: assert property (p_idx_step) else $error("index did not step");

endmodule
`default_nettype wire

// ===== tb/cal_host_model.sv
/*
  Host software model: drives register requests on the plain strobe port.
  Assumes the device answers reads in the cycle after the strobe.
*/
`timescale 1ns/1ps
`default_nettype none
module cal_host_model
  import cal_ctrl_pkg::*;
(
  // clock
  input wire logic mclk_i,
  // register port
  output reg_req_s req_o,
  input wire logic [7:0] rd_data_i
);
  initial req_o = '0;

  // one-cycle write strobe, port address repeated without re-addressing
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge mclk_i);
    req_o <= '{addr: a, wdata: v, we: 1'b1, re: 1'b0};
    @(posedge mclk_i);
    req_o <= '0;
  endtask

  // one-cycle read strobe, data taken at the edge that closes the answer cycle
  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    @(posedge mclk_i);
    req_o <= '{addr: a, wdata: 8'h00, we: 1'b0, re: 1'b1};
    @(posedge mclk_i);
    req_o <= '0;
    @(posedge mclk_i);
    v = rd_data_i;
  endtask
endmodule
`default_nettype wire

// ===== tb/test_adc_calibration_control_regs.sv
/*
  Self-checking bench for the calibration control register bank.
  Assumes the host model and the design package are compiled first.
*/
`timescale 1ns/1ps
`default_nettype none
module test_adc_calibration_control_regs;
  import cal_ctrl_pkg::*;
  logic mclk_i = 1'b0;
  logic rst_i = 1'b1;
  logic hw_trig = 1'b0;
  reg_req_s req;
  logic [7:0] rd_data;
  logic [7:0] gain;
  logic sleep_o;
  logic run_o;
  logic [7:0] d;
  int err_count = 0;
  int comparisons = 0;
  int cyc = 0;
  int n;

  initial forever #5 mclk_i = ~mclk_i;

  cal_host_model i_host (.mclk_i(mclk_i), .req_o(req), .rd_data_i(rd_data));

  cal_ctrl_regs #(.DLY_UNIT(1), .GAIN_TRIM_A_FACTORY(8'h80)) i_dut (
    .mclk_i(mclk_i),
    .rst_i(rst_i),
    .reg_req_i(req),
    .rd_data_o(rd_data),
    .hardware_cal_trigger_i(hw_trig),
    .core_sleep_o(sleep_o),
    .cal_running_o(run_o),
    .gain_trim_a_o(gain)
  );

  function automatic logic [7:0] pat(input int i);
    pat = 8'(i * 37 + 11);
  endfunction

  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    comparisons++;
    if (g !== e) begin
      err_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  task automatic rchk(input logic [7:0] a, input logic [7:0] e);
    i_host.rd(a, d);
    chk(d, e);
  endtask

  // waits for sleep output level v, returns cycles waited
  task automatic wait_sleep(input logic v, output int k);
    k = 0;
    while (sleep_o !== v && k < 300) begin
      @(posedge mclk_i);
      k++;
    end
  endtask

  task automatic end_sim;
    $display("errors=%0d comparisons=%0d", err_count, comparisons);
    if (err_count == 0 && comparisons > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  always @(posedge mclk_i) begin
    cyc++;
    if (cyc == 20000) begin
      err_count++;
      end_sim();
    end
  end

  initial begin
    repeat (12) @(posedge mclk_i);
    rst_i <= 1'b0;
    // reset values and unmapped address
    rchk(ADDR_LP_CTRL, {3'h2, 2'h1, 3'h0});
    rchk(ADDR_DATA_EN, 8'h00);
    rchk(ADDR_GAIN_A, 8'h80);
    chk(gain, 8'h80);
    rchk(8'h55, 8'h00);
    rchk(ADDR_STATUS, 8'h01);
    // port gated while disabled, calibration halted throughout
    i_host.wr(ADDR_DATA_PORT, 8'h5A);
    rchk(ADDR_DATA_PORT, 8'h00);
    i_host.wr(ADDR_DATA_EN, 8'h01);
    for (int i = 0; i < 673; i++) i_host.wr(ADDR_DATA_PORT, pat(i));
    i_host.wr(ADDR_DATA_EN, 8'h00);
    i_host.wr(ADDR_DATA_EN, 8'h01);
    for (int i = 0; i < 673; i++) rchk(ADDR_DATA_PORT, pat(i));
    rchk(ADDR_DATA_PORT, pat(0));
    i_host.wr(ADDR_DATA_EN, 8'h00);
    // gain trim write and readback
    i_host.wr(ADDR_GAIN_A, 8'h3C);
    rchk(ADDR_GAIN_A, 8'h3C);
    chk(gain, 8'h3C);
    // low-power off: cores never sleep
    i_host.wr(ADDR_LP_CTRL, 8'h00);
    i_host.wr(ADDR_TRIG_CTRL, 8'h02);
    n = 0;
    repeat (60) begin
      @(posedge mclk_i);
      if (sleep_o !== 1'b0) n++;
    end
    chk(8'(n), 8'h00);
    // timed mode, codes 0: sleep and wake of 9 clocks each
    i_host.wr(ADDR_LP_CTRL, 8'h01);
    wait_sleep(1'b1, n);
    wait_sleep(1'b0, n);
    chk(8'(n), 8'h09);
    n = 1;
    while (run_o !== 1'b1 && n < 300) begin
      @(posedge mclk_i);
      if (run_o !== 1'b1) n++;
    end
    chk(8'(n), 8'h09);
    // trigger mode, software source, hardware input ignored
    i_host.wr(ADDR_SOFT_TRIG, 8'h00);
    i_host.wr(ADDR_LP_CTRL, 8'h03);
    wait_sleep(1'b1, n);
    hw_trig <= 1'b1;
    n = 0;
    repeat (40) begin
      @(posedge mclk_i);
      if (sleep_o !== 1'b1) n++;
    end
    chk(8'(n), 8'h00);
    rchk(ADDR_STATUS, 8'h02);
    // hardware source selected: high input wakes the cores
    i_host.wr(ADDR_TRIG_CTRL, 8'h03);
    wait_sleep(1'b0, n);
    chk(8'(n < 4), 8'h01);
    hw_trig <= 1'b0;
    i_host.wr(ADDR_TRIG_CTRL, 8'h02);
    wait_sleep(1'b1, n);
    i_host.wr(ADDR_SOFT_TRIG, 8'h01);
    wait_sleep(1'b0, n);
    chk(8'(n < 4), 8'h01);
    end_sim();
  end
endmodule
`default_nettype wire
